/* File: cpu_flag_model.sv */
`timescale 1ns/1ns
module cpu_flag_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       add_wr,
    input  wire logic [4:0] flags,
    output logic [4:0]      sticky
);
    // cpu collects flags
    // sticky, so a whole burst of ops is judged once at its end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sticky <= 5'h00;
        end else if (add_wr) begin
            sticky <= sticky | flags;
        end
    end
endmodule

/* File: fp_abs_add_datapath.sv */
`timescale 1ns/1ns
// Overview of operation
// - single abs decoded by 111100, reserved zero
// - abs of infinity gives +infinity, flag
// - abs NaN gives canonical NaN, flags
// - double abs writes low E1, high E2
// - double add decoded by 0011000 / 110
// - single add decoded by 0010000 / 110
// - double add reads two cycles, writes E6/E7
// - any rounding sets inexact
// - NaN addend gives canonical NaN, invalid only if signaling
// - opposite infinities give NaN, invalid
// - single infinity passes through, flagged
// - overflow result per mode, inexact, overflow
// - underflow result per mode, inexact, underflow
// - exact cancellation gives +0, -0 toward minus
// - like-signed zeros or denormals keep sign
// - denormal addend is zero, flags set
// - single add four cycles, full throughput
module fp_abs_add_datapath
    import fp_abs_add_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        abs_valid,
    input  wire logic [31:0] abs_opcode,
    input  wire logic [31:0] abs_src2_lo,
    input  wire logic [31:0] abs_src2_hi,
    output logic             abs_wr,
    output logic             abs_wr_hi,
    output logic [31:0]      abs_result,
    output logic             abs_inexact_flag,
    output logic             abs_invalid_flag,
    output logic             abs_infinity_result_flag,
    output logic             second_src_nan_flag,
    output logic             second_src_denormal_flag,
    input  wire logic        add_valid,
    input  wire logic [31:0] add_opcode,
    input  wire logic [31:0] add_src1,
    input  wire logic [31:0] add_src2,
    input  wire logic [1:0]  round_mode,
    output logic             add_busy,
    output logic             add_wr,
    output logic             add_wr_hi,
    output logic [31:0]      add_result,
    output logic             inexact_flag,
    output logic             invalid_flag,
    output logic             overflow_flag,
    output logic             underflow_flag,
    output logic             infinity_result_flag,
    output logic [1:0]       denormal_source_flag,
    output logic [1:0]       nan_source_flag
);
    typedef struct packed {
        logic               busy;
        logic [31:0]        lo1;
        logic [31:0]        lo2;
        logic [1:0]         rm;
        wslot_t             abs_out;
        wslot_t             abs_pend;
        wslot_t [NSLOT-1:0] slot;
    } state_t;

    state_t      st_r;
    state_t      st_nxt;
    fpcls_t      cx;
    fpcls_t      ca;
    fpcls_t      cb;
    logic [63:0] abs_in;
    logic [63:0] opa;
    logic [63:0] opb;
    logic        abs_sp;
    logic        abs_dp;
    logic        add_sp;
    logic        add_dp;

    function automatic logic [63:0] pk(input logic dp, input logic sg,
                                       input logic [10:0] e,
                                       input logic [52:0] m);
        return dp ? {sg, e, m[51:0]} : {32'h0, sg, e[7:0], m[51:29]};
    endfunction

    function automatic logic [5:0] lzc(input logic [55:0] v);
        logic [5:0] n;
        logic       f;
        n = 6'h0;
        f = 1'b0;
        for (int i = 55; i >= 0; i--) begin
            if (!f && !v[i]) begin
                n = n + 6'h1;
            end else begin
                f = 1'b1;
            end
        end
        return n;
    endfunction

    function automatic addres_t fp_add(input fpcls_t a_in, input fpcls_t b_in,
                                       input logic dp, input logic [1:0] rm);
        addres_t     r;
        fpcls_t      a;
        fpcls_t      b;
        logic [56:0] xa;
        logic [56:0] xb;
        logic [56:0] sum;
        logic [56:0] nrm;
        logic [56:0] rnd;
        logic [12:0] e;
        logic [12:0] emax;
        logic [10:0] d;
        logic [5:0]  lz;
        logic        g;
        logic        s;
        logic        lsb;
        logic        up;
        logic        sg;
        logic        za;
        logic        zb;
        r    = '0;
        a    = a_in;
        b    = b_in;
        nrm  = '0;
        rnd  = '0;
        lz   = 6'h0;
        g    = 1'b0;
        s    = 1'b0;
        up   = 1'b0;
        emax = dp ? DP_EMAX : SP_EMAX;
        za   = a.zero | a.den;
        zb   = b.zero | b.den;
        r.flags[F_DEN1] = a.den;
        r.flags[F_SECOND_SRC_DENORMAL_FLAG] = b.den;
        r.flags[F_NAN1] = a.nan;
        r.flags[F_SECOND_SRC_NAN_FLAG] = b.nan;
        if (a.nan || b.nan) begin
            r.word = dp ? DP_NAN : {32'h0, SP_NAN};
            r.flags[F_INVALID_FLAG] = a.snan | b.snan;
        end else if (a.inf && b.inf && (a.sign != b.sign)) begin
            r.word = dp ? DP_NAN : {32'h0, SP_NAN};
            r.flags[F_INVALID_FLAG] = 1'b1;
        end else if (a.inf || b.inf) begin
            sg = a.inf ? a.sign : b.sign;
            r.word = dp ? {sg, DP_INF[62:0]} : {32'h0, sg, SP_INF[30:0]};
            r.flags[F_INFINITY_RESULT_FLAG] = 1'b1;
        end else begin
            r.flags[F_INEXACT_FLAG] = a.den | b.den;
            if (za && zb) begin
                sg = (a.sign == b.sign) ? a.sign : (rm == RM_NEG);
                r.word = pk(dp, sg, 11'h0, 53'h0);
            end else if (za || zb) begin
                r.word = za ? pk(dp, b.sign, b.exp, b.mant)
                            : pk(dp, a.sign, a.exp, a.mant);
            end else begin
                if ({a.exp, a.mant} < {b.exp, b.mant}) begin
                    a = b_in;
                    b = a_in;
                end
                d  = a.exp - b.exp;
                xa = {1'b0, a.mant, 3'h0};
                xb = {1'b0, b.mant, 3'h0};
                // shifted-out bits fold into a sticky bit
                s  = (d > 11'h038) ? |xb : |(xb & ~({57{1'b1}} << d));
                xb = (d > 11'h038) ? 57'h0 : (xb >> d);
                xb[0] = xb[0] | s;
                sum = (a.sign == b.sign) ? xa + xb : xa - xb;
                e   = {2'h0, a.exp};
                if (sum == 57'h0) begin
                    r.word = pk(dp, rm == RM_NEG, 11'h0, 53'h0);
                end else begin
                    if (sum[56]) begin
                        nrm    = {1'b0, sum[56:1]};
                        nrm[0] = nrm[0] | sum[0];
                        e      = e + 13'h1;
                    end else begin
                        lz  = lzc(sum[55:0]);
                        nrm = sum << lz;
                        e   = e - {7'h0, lz};
                    end
                    g   = dp ? nrm[2] : nrm[31];
                    s   = dp ? |nrm[1:0] : |nrm[30:0];
                    lsb = dp ? nrm[3] : nrm[32];
                    case (rm)
                        RM_NEAR: up = g & (s | lsb);
                        RM_ZERO: up = 1'b0;
                        RM_POS:  up = (g | s) & !a.sign;
                        default: up = (g | s) & a.sign;
                    endcase
                    rnd = nrm & ~(dp ? 57'h7 : 57'hffffffff);
                    rnd = rnd + (up ? (dp ? 57'h8 : 57'h100000000) : 57'h0);
                    if (rnd[56]) begin
                        rnd = rnd >> 1;
                        e   = e + 13'h1;
                    end
                    sg = a.sign;
                    r.flags[F_INEXACT_FLAG] = g | s;
                    if (!e[12] && (e >= emax)) begin
                        r.flags[F_INEXACT_FLAG] = 1'b1;
                        r.flags[F_OVER] = 1'b1;
                        if ((rm == RM_NEAR) || (rm == RM_POS && !sg) ||
                            (rm == RM_NEG && sg)) begin
                            r.word = pk(dp, sg, emax[10:0], 53'h0);
                        end else begin
                            e = emax - 13'h1;
                            r.word = pk(dp, sg, e[10:0], MANT_MAX);
                        end
                    end else if (e[12] || (e == 13'h0)) begin
                        r.flags[F_INEXACT_FLAG]  = 1'b1;
                        r.flags[F_UNDER] = 1'b1;
                        if ((rm == RM_POS && !sg) || (rm == RM_NEG && sg)) begin
                            r.word = pk(dp, sg, 11'h1, 53'h0);
                        end else begin
                            r.word = pk(dp, sg, 11'h0, 53'h0);
                        end
                    end else begin
                        r.word = pk(dp, sg, e[10:0], rnd[55:3]);
                    end
                end
            end
        end
        return r;
    endfunction

    // double abs reads both words in one cycle
    assign abs_in = abs_dp ? {abs_src2_hi, abs_src2_lo}
                           : {32'h0, abs_src2_lo};
    // double add: high words arrive the cycle after the low words
    assign opa = st_r.busy ? {add_src1, st_r.lo1} : {32'h0, add_src1};
    assign opb = st_r.busy ? {add_src2, st_r.lo2} : {32'h0, add_src2};

    // decodes sit outside the state process so the abs classifier,
    // which depends on abs_dp, does not feed back into that process
    // single and double abs decodes, single add decode
    assign abs_sp = abs_valid && (abs_opcode[11:6] == ABS_SP_OPF) &&
                    (abs_opcode[17:13] == ABS_RSV) &&
                    (abs_opcode[5:2] == ABS_TAIL);
    assign abs_dp = abs_valid && (abs_opcode[11:6] == ABS_DP_OPF) &&
                    (abs_opcode[17:13] == ABS_RSV) &&
                    (abs_opcode[5:2] == ABS_TAIL);
    assign add_sp = add_valid && !st_r.busy &&
                    (add_opcode[11:5] == ADD_SP_OPF) &&
                    (add_opcode[4:2] == ADD_TAIL);
    // double add decode; unit locked while busy
    assign add_dp = add_valid && !st_r.busy &&
                    (add_opcode[11:5] == ADD_DP_OPF) &&
                    (add_opcode[4:2] == ADD_TAIL);

    fp_classify u_cls_abs (
        .word    (abs_in),
        .dp      (abs_dp),
        .sign    (cx.sign),
        .expo    (cx.exp),
        .mant    (cx.mant),
        .is_zero (cx.zero),
        .is_den  (cx.den),
        .is_inf  (cx.inf),
        .is_nan  (cx.nan),
        .is_snan (cx.snan)
    );

    fp_classify u_cls_a (
        .word    (opa),
        .dp      (st_r.busy),
        .sign    (ca.sign),
        .expo    (ca.exp),
        .mant    (ca.mant),
        .is_zero (ca.zero),
        .is_den  (ca.den),
        .is_inf  (ca.inf),
        .is_nan  (ca.nan),
        .is_snan (ca.snan)
    );

    fp_classify u_cls_b (
        .word    (opb),
        .dp      (st_r.busy),
        .sign    (cb.sign),
        .expo    (cb.exp),
        .mant    (cb.mant),
        .is_zero (cb.zero),
        .is_den  (cb.den),
        .is_inf  (cb.inf),
        .is_nan  (cb.nan),
        .is_snan (cb.snan)
    );

    always_comb begin
        logic [63:0] aw;
        logic [8:0]  af;
        addres_t     res;
        aw = 64'h0;
        af = 9'h0;
        st_nxt = st_r;
        res = '0;

        if (cx.nan) begin
            aw = abs_dp ? DP_NAN : {32'h0, SP_NAN};
            af[F_SECOND_SRC_NAN_FLAG]  = 1'b1;
            af[F_INVALID_FLAG] = cx.snan;
        end else if (cx.inf) begin
            aw = abs_dp ? DP_INF : {32'h0, SP_INF};
            af[F_INFINITY_RESULT_FLAG] = 1'b1;
        end else if (cx.den) begin
            af[F_INEXACT_FLAG] = 1'b1;
            af[F_SECOND_SRC_DENORMAL_FLAG] = 1'b1;
        end else begin
            aw = abs_in & {1'b0, {31{1'b1}}, abs_dp, {31{1'b1}}};
        end

        st_nxt.abs_out  = st_r.abs_pend;
        st_nxt.abs_pend = '0;
        // a pending high word wins; a new abs in that cycle is dropped
        if (!st_r.abs_pend.v && (abs_sp || abs_dp)) begin
            st_nxt.abs_out = '{v: 1'b1, hi: 1'b0, word: aw[31:0],
                               flags: (abs_dp ? 9'h0 : af)};
            if (abs_dp) begin
                st_nxt.abs_pend = '{v: 1'b1, hi: 1'b1, word: aw[63:32],
                                    flags: af};
            end
        end

        for (int i = 0; i < NSLOT - 1; i++) begin
            st_nxt.slot[i] = st_r.slot[i + 1];
        end
        st_nxt.slot[NSLOT-1] = '0;

        // rounding mode taken with the issue
        res = fp_add(ca, cb, st_r.busy, st_r.busy ? st_r.rm : round_mode);
        st_nxt.busy = add_dp;
        if (add_dp) begin
            st_nxt.lo1 = add_src1;
            st_nxt.lo2 = add_src2;
            st_nxt.rm  = round_mode;
        end
        // single add result after three slots
        if (add_sp) begin
            st_nxt.slot[SP_ADD_SLOT] = '{v: 1'b1, hi: 1'b0,
                                         word: res.word[31:0],
                                         flags: res.flags};
        end
        // double add low then high word
        if (st_r.busy) begin
            st_nxt.slot[DP_LO_SLOT] = '{v: 1'b1, hi: 1'b0,
                                        word: res.word[31:0], flags: 9'h0};
            st_nxt.slot[DP_HI_SLOT] = '{v: 1'b1, hi: 1'b1,
                                        word: res.word[63:32],
                                        flags: res.flags};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign abs_wr                   = st_r.abs_out.v;
    assign abs_wr_hi                = st_r.abs_out.hi;
    assign abs_result               = st_r.abs_out.word;
    assign abs_inexact_flag         = st_r.abs_out.flags[F_INEXACT_FLAG];
    assign abs_invalid_flag         = st_r.abs_out.flags[F_INVALID_FLAG];
    assign abs_infinity_result_flag = st_r.abs_out.flags[F_INFINITY_RESULT_FLAG];
    assign second_src_nan_flag      = st_r.abs_out.flags[F_SECOND_SRC_NAN_FLAG];
    assign second_src_denormal_flag = st_r.abs_out.flags[F_SECOND_SRC_DENORMAL_FLAG];
    assign add_busy                 = st_r.busy;
    assign add_wr                   = st_r.slot[0].v;
    assign add_wr_hi                = st_r.slot[0].hi;
    assign add_result               = st_r.slot[0].word;
    assign inexact_flag             = st_r.slot[0].flags[F_INEXACT_FLAG];
    assign invalid_flag             = st_r.slot[0].flags[F_INVALID_FLAG];
    assign overflow_flag            = st_r.slot[0].flags[F_OVER];
    assign underflow_flag           = st_r.slot[0].flags[F_UNDER];
    assign infinity_result_flag     = st_r.slot[0].flags[F_INFINITY_RESULT_FLAG];
    assign denormal_source_flag     = {st_r.slot[0].flags[F_SECOND_SRC_DENORMAL_FLAG],
                                       st_r.slot[0].flags[F_DEN1]};
    assign nan_source_flag          = {st_r.slot[0].flags[F_SECOND_SRC_NAN_FLAG],
                                       st_r.slot[0].flags[F_NAN1]};

    a_abs_sp_plain: assert property (
        @(posedge clock) disable iff (!rst_n)
        abs_sp && !st_r.abs_pend.v && !cx.nan && !cx.inf && !cx.den
        |=> abs_wr && !abs_wr_hi &&
            abs_result == ($past(abs_src2_lo) & 32'h7fffffff))
        else $error("single abs result wrong");

    a_abs_inf_out: assert property (
        @(posedge clock) disable iff (!rst_n)
        abs_sp && !st_r.abs_pend.v && cx.inf
        |=> abs_result == SP_INF && abs_infinity_result_flag)
        else $error("abs of infinity wrong");

    a_abs_canonical_nan_value: assert property (
        @(posedge clock) disable iff (!rst_n)
        abs_sp && !st_r.abs_pend.v && cx.nan
        |=> abs_result == SP_NAN && second_src_nan_flag &&
            abs_invalid_flag == $past(cx.snan))
        else $error("abs of nan wrong");

    a_abs_dp_order: assert property (
        @(posedge clock) disable iff (!rst_n)
        abs_dp && !st_r.abs_pend.v
        |=> abs_wr && !abs_wr_hi ##1 abs_wr && abs_wr_hi)
        else $error("double abs word order wrong");

    a_abs_den_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        abs_sp && !st_r.abs_pend.v && cx.den
        |=> abs_result == 32'h0 && abs_inexact_flag &&
            second_src_denormal_flag)
        else $error("abs of denormal wrong");

    a_add_sp_latency: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_sp |=> !add_busy ##3 add_wr && !add_wr_hi)
        else $error("single add latency wrong");

    a_add_dp_latency: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_dp |=> add_busy ##5 add_wr && !add_wr_hi ##1 add_wr && add_wr_hi)
        else $error("double add write timing wrong");

    a_add_snan_invalid_flag: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_sp && (ca.snan || cb.snan)
        |-> ##4 add_result == SP_NAN && invalid_flag)
        else $error("signaling nan add wrong");

    a_add_inf_cancel: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_sp && ca.inf && cb.inf && (ca.sign != cb.sign)
        |-> ##4 add_result == SP_NAN && invalid_flag && !infinity_result_flag)
        else $error("opposite infinities wrong");

    a_ovf_inexact: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_wr && (overflow_flag || underflow_flag) |-> inexact_flag)
        else $error("range error without inexact");

    a_cancel_negzero: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_sp && !ca.zero && !ca.den && !ca.inf && !ca.nan &&
        ca.exp == cb.exp && ca.mant == cb.mant && ca.sign != cb.sign &&
        round_mode == RM_NEG
        |-> ##4 add_result == 32'h80000000 && !inexact_flag)
        else $error("cancellation sign wrong");

    a_den_src_inexact: assert property (
        @(posedge clock) disable iff (!rst_n)
        add_sp && ca.den && !cb.nan && !cb.inf
        |-> ##4 inexact_flag && denormal_source_flag[0])
        else $error("denormal source flags wrong");
endmodule

/* File: fp_abs_add_datapath_tb_top.sv */
`timescale 1ns/1ns
module fp_abs_add_datapath_tb_top
    import fp_abs_add_pkg::*;
;
    localparam logic [31:0] SPA = {20'h00000, ADD_SP_OPF, ADD_TAIL, 2'h0};
    localparam logic [31:0] DPA = {20'h00000, ADD_DP_OPF, ADD_TAIL, 2'h0};
    localparam logic [31:0] SPB = {14'h0, ABS_RSV, 1'h0, ABS_SP_OPF,
                                   ABS_TAIL, 2'h0};
    localparam logic [31:0] DPB = {14'h0, ABS_RSV, 1'h0, ABS_DP_OPF,
                                   ABS_TAIL, 2'h0};
    logic        clock = 0, rst_n = 0, abs_valid = 0, add_valid = 0;
    logic [31:0] abs_opcode = 0, abs_src2_lo = 0, abs_src2_hi = 0;
    logic [31:0] add_opcode = 0, add_src1 = 0, add_src2 = 0;
    logic [1:0]  round_mode = 0;
    logic        abs_wr, abs_wr_hi, abs_inexact_flag, abs_invalid_flag;
    logic        abs_infinity_result_flag, second_src_nan_flag, add_wr;
    logic        second_src_denormal_flag, add_busy, add_wr_hi;
    logic        inexact_flag, invalid_flag, overflow_flag, underflow_flag;
    logic        infinity_result_flag;
    logic [31:0] abs_result, add_result;
    logic [1:0]  denormal_source_flag, nan_source_flag;
    logic [4:0]  sticky;
    int          error_cnt = 0;
    int          n_checks = 0;
    fp_abs_add_datapath fp_abs_add_datapath_i (.*);
    cpu_flag_model cpu_flag_model_i (.clock(clock), .rst_n(rst_n),
        .add_wr(add_wr), .sticky(sticky), .flags({inexact_flag,
        invalid_flag, overflow_flag, underflow_flag, infinity_result_flag}));
    always #25 clock = ~clock;
    task automatic chk(input string nm, input logic [39:0] s, e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic t_abs(input logic [31:0] op, lo, r, input logic ok,
                         input logic [4:0] f);
        @(posedge clock);
        abs_valid <= 1'h1;
        abs_opcode <= op;
        abs_src2_lo <= lo;
        abs_src2_hi <= r ^ 32'h80000000;
        @(posedge clock);
        abs_valid <= 1'h0;
        #1;
        if (op == DPB) begin
            chk("abs lo", {abs_wr, abs_wr_hi, abs_result}, {2'h2, lo});
            @(posedge clock);
            #1;
        end
        chk("abs wr", abs_wr, ok);
        chk("abs result", abs_result, r);
        chk("abs flags", {abs_inexact_flag, abs_invalid_flag,
            abs_infinity_result_flag, second_src_nan_flag,
            second_src_denormal_flag}, f);
    endtask
    task automatic t_add(input logic [31:0] a, b, input logic [1:0] rm,
                         input logic [31:0] r, input logic [8:0] f);
        @(posedge clock);
        add_valid <= 1'h1;
        add_opcode <= SPA;
        add_src1 <= a;
        add_src2 <= b;
        round_mode <= rm;
        @(posedge clock);
        add_valid <= 1'h0;
        repeat (3) @(posedge clock);
        #1;
        chk("add wr", add_wr, 1'h1);
        chk("add result", add_result, r);
        chk("add flags", {inexact_flag, invalid_flag, overflow_flag,
            underflow_flag, infinity_result_flag, denormal_source_flag,
            nan_source_flag}, f);
    endtask
    task automatic test_abs();
        t_abs(SPB, 32'hc0200000, 32'h40200000, 1'h1, 5'h00);
        t_abs(SPB, 32'hff800000, 32'h7f800000, 1'h1, 5'h04);
        t_abs(SPB, 32'h7f800001, 32'h7fffffff, 1'h1, 5'h0a);
        t_abs(SPB, 32'h7fc00000, 32'h7fffffff, 1'h1, 5'h02);
        t_abs(SPB, 32'h80000001, 32'h00000000, 1'h1, 5'h11);
        // reserved field nonzero must not decode
        t_abs(SPB | 32'h2000, 32'hc0200000, 32'h0, 1'h0, 5'h00);
        t_abs(DPB, 32'h12345678, 32'h40040000, 1'h1, 5'h00);
        $display("abs test done");
    endtask
    task automatic test_add();
        t_add(32'hc0200000, 32'h4109999a, RM_NEAR, 32'h40c33334, 0);
        t_add(32'h7f800000, 32'hff800000, RM_NEAR, SP_NAN, 9'h080);
        t_add(32'hff800000, 32'h3f800000, RM_NEAR, 32'hff800000,
              9'h010);
        t_add(32'h7f800001, 32'h3f800000, RM_NEAR, SP_NAN, 9'h081);
        t_add(32'h3f800000, 32'hbf800000, RM_NEAR, 32'h0, 0);
        t_add(32'h3f800000, 32'hbf800000, RM_NEG, 32'h80000000, 0);
        t_add(32'h7f7fffff, 32'h7f7fffff, RM_NEAR, SP_INF, 9'h140);
        t_add(32'h7f7fffff, 32'h7f7fffff, RM_ZERO, 32'h7f7fffff,
              9'h140);
        t_add(32'hff7fffff, 32'hff7fffff, RM_POS, 32'hff7fffff,
              9'h140);
        t_add(32'hff7fffff, 32'hff7fffff, RM_NEG, 32'hff800000,
              9'h140);
        t_add(32'h00800001, 32'h80800000, RM_NEAR, 32'h0, 9'h120);
        t_add(32'h00800001, 32'h80800000, RM_POS, 32'h00800000,
              9'h120);
        t_add(32'h80000000, 32'h80000000, RM_NEAR, 32'h80000000, 0);
        t_add(32'h00000001, 32'h3f800000, RM_NEAR, 32'h3f800000,
              9'h104);
        $display("add test done");
    endtask
    task automatic test_dp_add();
        @(posedge clock);
        add_valid <= 1'h1;
        add_opcode <= DPA;
        add_src1 <= 32'h33333333;
        add_src2 <= 32'h00000000;
        @(posedge clock);
        add_valid <= 1'h0;
        add_src1 <= 32'h40213333;
        add_src2 <= 32'hc0040000;
        #1;
        chk("add busy", add_busy, 1'h1);
        repeat (5) @(posedge clock);
        #1;
        chk("dp lo", {add_wr, add_wr_hi, add_result},
            {2'h2, 32'h66666666});
        @(posedge clock);
        #1;
        chk("dp hi", {add_wr, add_wr_hi, add_result},
            {2'h3, 32'h40186666});
        $display("dp add test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // about 100 cycles of tests; a hang is cut off well past that
    initial begin
        #50000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'h1;
        test_abs();
        test_add();
        test_dp_add();
        chk("collected flags", sticky, 5'h1f);
        give_verdict();
    end
endmodule

/* File: fp_abs_add_pkg.sv */
package fp_abs_add_pkg;

    // opcode fields of the shift/logic unit absolute-value ops
    localparam logic [5:0] ABS_SP_OPF = 6'h3c;
    localparam logic [5:0] ABS_DP_OPF = 6'h2c;
    localparam logic [4:0] ABS_RSV    = 5'h00;
    localparam logic [3:0] ABS_TAIL   = 4'h8;

    // opcode fields of the arithmetic/logic unit add ops
    localparam logic [6:0] ADD_DP_OPF = 7'h18;
    localparam logic [6:0] ADD_SP_OPF = 7'h10;
    localparam logic [2:0] ADD_TAIL   = 3'h6;

    // rounding mode selection
    localparam logic [1:0] RM_NEAR = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_POS  = 2'h2;
    localparam logic [1:0] RM_NEG  = 2'h3;

    localparam logic [31:0] SP_NAN  = 32'h7fffffff;
    localparam logic [31:0] SP_INF  = 32'h7f800000;
    localparam logic [63:0] DP_NAN  = 64'h7fffffffffffffff;
    localparam logic [63:0] DP_INF  = 64'h7ff0000000000000;
    localparam logic [12:0] SP_EMAX = 13'h00ff;
    localparam logic [12:0] DP_EMAX = 13'h07ff;
    localparam logic [52:0] MANT_MAX = 53'h1fffffffffffff;

    // write-back slots, counted from the edge that computes the result
    localparam int SP_ADD_SLOT = 3;
    localparam int DP_LO_SLOT  = 4;
    localparam int DP_HI_SLOT  = 5;
    localparam int NSLOT       = 6;

    // exception flag positions
    localparam int F_INEXACT_FLAG  = 0;
    localparam int F_INVALID_FLAG = 1;
    localparam int F_OVER  = 2;
    localparam int F_UNDER = 3;
    localparam int F_INFINITY_RESULT_FLAG  = 4;
    localparam int F_DEN1  = 5;
    localparam int F_SECOND_SRC_DENORMAL_FLAG  = 6;
    localparam int F_NAN1  = 7;
    localparam int F_SECOND_SRC_NAN_FLAG  = 8;

    typedef struct packed {
        logic        v;
        logic        hi;
        logic [31:0] word;
        logic [8:0]  flags;
    } wslot_t;

    typedef struct packed {
        logic        sign;
        logic [10:0] exp;
        logic [52:0] mant;
        logic        zero;
        logic        den;
        logic        inf;
        logic        nan;
        logic        snan;
    } fpcls_t;

    typedef struct packed {
        logic [63:0] word;
        logic [8:0]  flags;
    } addres_t;

endpackage

/* File: fp_classify.sv */
`timescale 1ns/1ns
module fp_classify
    import fp_abs_add_pkg::*;
(
    input  wire logic [63:0] word,
    input  wire logic        dp,
    output logic             sign,
    output logic [10:0]      expo,
    output logic [52:0]      mant,
    output logic             is_zero,
    output logic             is_den,
    output logic             is_inf,
    output logic             is_nan,
    output logic             is_snan
);
    logic [51:0] frac;
    logic [10:0] e_all;

    always_comb begin
        sign    = dp ? word[63] : word[31];
        expo    = dp ? word[62:52] : {3'h0, word[30:23]};
        frac    = dp ? word[51:0] : {word[22:0], 29'h0};
        e_all   = dp ? DP_EMAX[10:0] : SP_EMAX[10:0];
        mant    = {1'b1, frac};
        is_zero = (expo == 11'h000) && (frac == 52'h0);
        is_den  = (expo == 11'h000) && (frac != 52'h0);
        is_inf  = (expo == e_all) && (frac == 52'h0);
        is_nan  = (expo == e_all) && (frac != 52'h0);
        // quiet nans carry the top fraction bit
        is_snan = is_nan && !frac[51];
    end
endmodule
